// ===== include/mrsync_pkg.sv
// Purpose: shared constants for the reset sequencer and rtc tick block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: all fields sit in the low byte of each word
package mrsync_pkg;
    localparam int ADDR_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_IN_LATCH0 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH0 = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_TICK = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 5'h1c;

    // ctrl fields
    localparam int CTRL_FORCE_BIT = 0;
    // status fields
    localparam int STAT_LIVE_BIT = 0;
    localparam int STAT_EXIT_BIT = 1;
    localparam int STAT_ENTRY_BIT = 2;
    localparam int STAT_LAST_BIT = 3;
    // input latch 0 fields
    localparam int IN_FLASH_WP_BIT = 0;
    localparam int IN_KEYLOCK_BIT = 1;
    localparam int IN_KBD_SECURE_BIT = 2;
    // output latch 0 fields
    localparam int OUT_LATCH_W = 5;
    localparam int OUT_VIDEO_BIT = 0;
    localparam int OUT_FLOPPY_BIT = 1;
    localparam int OUT_SECURE_BIT = 2;
    localparam int OUT_FAN_BIT = 3;
    localparam int OUT_KEYLOCK_BIT = 4;
    localparam logic [OUT_LATCH_W-1:0] OUT_LATCH_RESET = 5'h1a;
    // interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_EXIT_BIT = 0;
    localparam int IRQ_ENTRY_BIT = 1;
    localparam int IRQ_SAT_BIT = 2;

    // rtc tick chain
    localparam int PRESCALE_W = 3;
    localparam int TICK_W = 8;
    localparam logic [TICK_W-1:0] TICK_MAX = 8'hff;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 3'h7;

    // shortest processor reset pulse that must be seen
    localparam int CLK_PERIOD_NS = 8;
    localparam int MIN_RESET_PULSE_NS = 80;
    localparam int MIN_RESET_PULSE_CYC = MIN_RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
endpackage

// ===== rtl/mrsync_sync.sv
// Purpose: two-flop synchronisers for a group of pin inputs
// Assumes: each bit changes slower than the clock
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module mrsync_sync
    import mrsync_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= din[i];
                    stage2 <= stage1;
                end
            end
            assign dout[i] = stage2;
        end
    endgenerate
endmodule

// ===== rtl/mrsync_top.sv
// Purpose: reset sequencing, reset event latches, output latch and rtc tick counter
// Assumes: axi4-lite slave, one write and one read in flight
// Notes: pin inputs and the rtc clock are sampled on clk
//
// Overview of operation
// R01: power-ok low while force latch set, supply low or front-panel reset active.
// R02: live status bit reads 1 while processors sit in reset, unlatched.
// R03: exit flag sets on leaving reset, clears on read and on supply loss.
// R04: entry flag sets on entering reset, clears on read and on supply loss.
// R05: reset pulses near 80 ns still produce entry and exit flags.
// R06: front-panel reset indicator is the inverse of the active-low processor reset.
// R07: firmware sets the force-reset latch; supply loss clears it.
// R08: controller reset high while supply low or reset request active, else low.
// R09: last-reset latch clears on supply loss, sets on request with supply good.
// R10: last-reset latch is read-only; writes never change it.
// R11: output latch 0 bits drive video, floppy, secure, fan led and keylock lines.
// R12: firmware should mirror keylock request input into keylock output bit.
// R13: flash write-protect pin is readable in input latch 0.
// R14: 8-bit tick counter advances once per eight rtc periods via 3-bit prescaler.
// R15: reading the tick counter returns it and clears it.
// R16: tick counter saturates at ff instead of wrapping.
// R17: firmware accumulates reads, treats ff as error, shifts total right twelve.
// R18: pin inputs and rtc clock pass two flops before any logic.
// R19: a set in the same cycle as a clear-on-read wins.
`timescale 1ns/100ps
module mrsync_top
    import mrsync_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic supply_ok_in,
    input wire logic front_panel_a,
    input wire logic cpu_reset_n,
    input wire logic mgmt_reset_request_n,
    input wire logic flash_wp_n,
    input wire logic keylock_request_in_n,
    input wire logic keyboard_secure_in_n,
    input wire logic rtc_clk,
    output logic cpu_power_ok_control,
    output logic system_reset_indicator,
    output logic mgmt_controller_reset,
    output logic video_blank,
    output logic floppy_write_inhibit_n,
    output logic secure_state_out,
    output logic fan_fault_led_n,
    output logic keylock_out_n,
    output logic irq
);
    localparam int NSYNC = 8;

    // synchronised pins
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s;
    logic supply_s;
    logic hard_s;
    logic cpu_reset_n_s;
    logic req_n_s;
    logic flash_wp_n_s;
    logic keylock_req_n_s;
    logic kbd_secure_n_s;
    logic rtc_s;

    assign pins_raw = {rtc_clk, keyboard_secure_in_n, keylock_request_in_n, flash_wp_n,
                       mgmt_reset_request_n, cpu_reset_n, front_panel_a, supply_ok_in};

    mrsync_sync #(.WIDTH(NSYNC)) mrsync_sync_inst (
        .clk(clk),
        .rst(rst),
        .din(pins_raw), // R18
        .dout(pins_s)
    );

    assign supply_s = pins_s[0];
    assign hard_s = pins_s[1];
    assign cpu_reset_n_s = pins_s[2];
    assign req_n_s = pins_s[3];
    assign flash_wp_n_s = pins_s[4];
    assign keylock_req_n_s = pins_s[5];
    assign kbd_secure_n_s = pins_s[6];
    assign rtc_s = pins_s[7];

    // state
    logic force_reset;
    logic supply_d;
    logic live_d;
    logic exit_flag;
    logic entry_flag;
    logic last_reset_was_power_loss;
    logic [OUT_LATCH_W-1:0] out_latch;
    logic rtc_d;
    logic [PRESCALE_W-1:0] prescale;
    logic [TICK_W-1:0] tick;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;

    // write channel bookkeeping
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;

    // handshakes and decode
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_have & w_have & ~s_axi_bvalid;
    wire wr_en = do_write & wr_lane0;
    wire wr_ctrl = wr_en & (wr_addr == OFS_CTRL);
    wire wr_out = wr_en & (wr_addr == OFS_OUT_LATCH0);
    wire wr_irq_en = wr_en & (wr_addr == OFS_IRQ_ENABLE);
    wire wr_irq_clr = wr_en & (wr_addr == OFS_IRQ_CLEAR);
    wire wr_mapped = (wr_addr == OFS_CTRL) | (wr_addr == OFS_OUT_LATCH0)
                     | (wr_addr == OFS_IRQ_ENABLE) | (wr_addr == OFS_IRQ_CLEAR);
    wire rd_status = ar_hs & (s_axi_araddr == OFS_STATUS);
    wire rd_tick = ar_hs & (s_axi_araddr == OFS_TICK);

    wire next_aw_have = (aw_have | aw_hs) & ~do_write;
    wire next_w_have = (w_have | w_hs) & ~do_write;
    wire next_bvalid = s_axi_bvalid ? ~s_axi_bready : do_write;
    wire next_rvalid = s_axi_rvalid ? ~s_axi_rready : ar_hs;

    // reset event detection; 80 ns is ten clocks, well over the sync depth
    wire live = ~cpu_reset_n_s; // R02
    // sync flops restart at zero, which would fake an exit edge after reset or supply loss
    wire edge_ok = supply_s & supply_d;
    wire entry_evt = edge_ok & live & ~live_d; // R04 R05
    wire exit_evt = edge_ok & ~live & live_d; // R03 R05

    // tick chain
    wire rtc_rise = rtc_s & ~rtc_d;
    wire tick_adv = rtc_rise & (prescale == PRESCALE_LAST); // R14
    wire tick_sat = (tick == TICK_MAX);
    wire tick_inc = tick_adv & ~tick_sat; // R16

    // set wins over clear-on-read
    wire next_exit = ~supply_s ? 1'b0 : (exit_evt | (exit_flag & ~rd_status)); // R03 R19
    wire next_entry = ~supply_s ? 1'b0 : (entry_evt | (entry_flag & ~rd_status)); // R04 R19
    wire next_force = ~supply_s ? 1'b0
                      : (wr_ctrl ? wr_byte[CTRL_FORCE_BIT] : force_reset); // R07
    wire next_last = ~supply_s ? 1'b0 : (~req_n_s | last_reset_was_power_loss); // R09 R10
    wire [TICK_W-1:0] tick_plus = tick + 8'h01;
    wire [TICK_W-1:0] next_tick = rd_tick ? (tick_inc ? 8'h01 : 8'h00) // R15 R19
                                  : (tick_inc ? tick_plus : tick);

    wire [IRQ_W-1:0] irq_events = {tick_adv & tick_sat, entry_evt, exit_evt};
    wire [IRQ_W-1:0] irq_clr_mask = wr_irq_clr ? wr_byte[IRQ_W-1:0] : '0;
    // events set even while their clear is written
    wire [IRQ_W-1:0] next_irq_status = irq_events | (irq_status & ~irq_clr_mask);
    wire [IRQ_W-1:0] next_irq_enable = wr_irq_en ? wr_byte[IRQ_W-1:0] : irq_enable;

    // read mux
    wire [7:0] status_byte = {4'h0, last_reset_was_power_loss, entry_flag, exit_flag, live};
    wire [7:0] in_byte = {5'h00, kbd_secure_n_s, keylock_req_n_s, flash_wp_n_s}; // R13
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_byte = {7'h00, force_reset};
            OFS_STATUS: rd_byte = status_byte; // R02
            OFS_IN_LATCH0: rd_byte = in_byte;
            OFS_OUT_LATCH0: rd_byte = {3'h0, out_latch};
            OFS_TICK: rd_byte = tick; // R15
            OFS_IRQ_STATUS: rd_byte = {5'h00, irq_status};
            OFS_IRQ_ENABLE: rd_byte = {5'h00, irq_enable};
            OFS_IRQ_CLEAR: rd_byte = 8'h00;
            default: rd_ok = 1'b0;
        endcase
    end

    // bus handshake flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            s_axi_awready <= ~next_aw_have;
            s_axi_wready <= ~next_w_have;
            s_axi_bvalid <= next_bvalid;
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // captured payloads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_addr <= '0;
            wr_byte <= 8'h00;
            wr_lane0 <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                wr_addr <= s_axi_awaddr;
            end
            if (w_hs) begin
                wr_byte <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (ar_hs) begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // reset latches and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            force_reset <= 1'b0;
            supply_d <= 1'b0;
            live_d <= 1'b0;
            exit_flag <= 1'b0;
            entry_flag <= 1'b0;
            last_reset_was_power_loss <= 1'b0;
        end else begin
            force_reset <= next_force; // R07
            supply_d <= supply_s;
            live_d <= live;
            exit_flag <= next_exit;
            entry_flag <= next_entry;
            last_reset_was_power_loss <= next_last; // R09
        end
    end

    // output latch, tick chain, interrupts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_latch <= OUT_LATCH_RESET;
            rtc_d <= 1'b0;
            prescale <= '0;
            tick <= 8'h00;
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            if (wr_out) begin
                out_latch <= wr_byte[OUT_LATCH_W-1:0]; // R11
            end
            rtc_d <= rtc_s;
            if (rtc_rise) begin
                prescale <= prescale + 3'h1; // R14
            end
            tick <= next_tick;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
        end
    end

    // pins out, all registered; reset holds cpu and controller in reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_power_ok_control <= 1'b0;
            system_reset_indicator <= 1'b1;
            mgmt_controller_reset <= 1'b1;
            video_blank <= OUT_LATCH_RESET[OUT_VIDEO_BIT];
            floppy_write_inhibit_n <= OUT_LATCH_RESET[OUT_FLOPPY_BIT];
            secure_state_out <= OUT_LATCH_RESET[OUT_SECURE_BIT];
            fan_fault_led_n <= OUT_LATCH_RESET[OUT_FAN_BIT];
            keylock_out_n <= OUT_LATCH_RESET[OUT_KEYLOCK_BIT];
            irq <= 1'b0;
        end else begin
            cpu_power_ok_control <= ~(force_reset | ~supply_s | hard_s); // R01
            system_reset_indicator <= ~cpu_reset_n_s; // R06
            mgmt_controller_reset <= ~supply_s | ~req_n_s; // R08
            video_blank <= out_latch[OUT_VIDEO_BIT]; // R11
            floppy_write_inhibit_n <= out_latch[OUT_FLOPPY_BIT];
            secure_state_out <= out_latch[OUT_SECURE_BIT];
            fan_fault_led_n <= out_latch[OUT_FAN_BIT];
            // firmware is expected to copy the keylock request here
            keylock_out_n <= out_latch[OUT_KEYLOCK_BIT]; // R12
            irq <= |(irq_status & irq_enable);
        end
    end
endmodule

// ===== tb/mrsync_monitor.sv
// Purpose: port checks for the reset sequencer and axi4-lite handshakes
// Assumes: pins reach outputs three edges after they are sampled
// Notes: gated three edges after reset while sync flops refill
`timescale 1ns/100ps
module mrsync_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_ok_in,
    input wire logic front_panel_a,
    input wire logic cpu_reset_n,
    input wire logic mgmt_reset_request_n,
    input wire logic cpu_power_ok_control,
    input wire logic system_reset_indicator,
    input wire logic mgmt_controller_reset
);
    logic [1:0] warm;
    wire logic warm_ok = warm == 2'h3;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            warm <= 2'h0;
        end else if (!warm_ok) begin
            warm <= warm + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    indic_inv_a:
    assert property (warm_ok |-> system_reset_indicator == !$past(cpu_reset_n, 3))
        else $error("indicator not the inverse of processor reset");
    power_off_a:
    assert property (warm_ok && (!$past(supply_ok_in, 3) || $past(front_panel_a, 3))
        |-> !cpu_power_ok_control)
        else $error("power ok high while supply low or panel reset");
    mreset_level_a:
    assert property (warm_ok |-> mgmt_controller_reset ==
        (!$past(supply_ok_in, 3) || !$past(mgmt_reset_request_n, 3)))
        else $error("controller reset level wrong");
    write_answer_a:
    assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a:
    assert property (ar_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
    write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    read_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not released");
    read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken with read pending");
endmodule

// ===== tb/mrsync_platform.sv
// Purpose: platform stand-in making processor reset pulses and rtc bursts
// Assumes: requests rise on clk edges
// Notes: 1 ns offset keeps pin edges off clk edges
`timescale 1ns/100ps
module mrsync_platform #(
    parameter int RTC_HALF_NS = 44
) (
    input wire logic pulse_go,
    input wire logic [15:0] pulse_ns,
    input wire logic burst_go,
    input wire logic [11:0] burst_len,
    output logic cpu_reset_n,
    output logic rtc_clk,
    output logic rtc_busy
);
    initial begin
        cpu_reset_n = 1'b1;
        rtc_clk = 1'b0;
        rtc_busy = 1'b0;
    end
    always @(posedge pulse_go) begin
        #1 cpu_reset_n = 1'b0;
        #(pulse_ns) cpu_reset_n = 1'b1;
    end
    // idles low so whole periods keep the prescaler phase
    always @(posedge burst_go) begin
        rtc_busy = 1'b1;
        #1;
        repeat (burst_len) begin
            #(RTC_HALF_NS) rtc_clk = 1'b1;
            #(RTC_HALF_NS) rtc_clk = 1'b0;
        end
        rtc_busy = 1'b0;
    end
endmodule

// ===== tb/mgmt_reset_and_rtc_sync_tb.sv
// Purpose: self-checking bench, plays firmware over axi4-lite
// Assumes: pins settle four edges after a change
// Notes: rtc runs fast so saturation fits the run
`timescale 1ns/100ps
module mgmt_reset_and_rtc_sync_tb;
    import mrsync_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = 5'h0;
    logic [ADDR_W-1:0] s_axi_araddr = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic supply_ok_in = 1'b1, front_panel_a = 1'b0, mgmt_reset_request_n = 1'b1;
    logic flash_wp_n = 1'b1, keylock_request_in_n = 1'b0, keyboard_secure_in_n = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic cpu_reset_n, rtc_clk, rtc_busy, cpu_power_ok_control, system_reset_indicator;
    logic mgmt_controller_reset, video_blank, floppy_write_inhibit_n, secure_state_out;
    logic fan_fault_led_n, keylock_out_n, irq;
    logic pulse_go = 1'b0, burst_go = 1'b0;
    logic [15:0] pulse_ns = 16'h0;
    logic [11:0] burst_len = 12'h0;
    wire logic [4:0] pins = {keylock_out_n, fan_fault_led_n, secure_state_out,
        floppy_write_inhibit_n, video_blank};
    int mismatches = 0;
    int check_count = 0;
    mrsync_top mrsync_top_inst (.*);
    mrsync_platform mrsync_platform_inst (.*);
    always #4 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_resp(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                           input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, r);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        wr_resp(a, d, RESP_OKAY);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        logic ar, v;
        logic [1:0] r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ar = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (v !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", RESP_OKAY, r);
    endtask
    task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(what, {24'h0, e}, d);
    endtask
    task automatic pulse(input logic [15:0] ns);
        pulse_ns <= ns;
        pulse_go <= 1'b1;
        step(1);
        pulse_go <= 1'b0;
    endtask
    task automatic burst(input logic [11:0] n);
        burst_len <= n;
        burst_go <= 1'b1;
        step(1);
        burst_go <= 1'b0;
        while (rtc_busy) step(1);
        step(4);
    endtask
    task automatic t_latch();
        logic [31:0] d;
        chk("latch reset pins", {27'h0, OUT_LATCH_RESET}, pins);
        rchk("latch reset", OFS_OUT_LATCH0, {3'h0, OUT_LATCH_RESET});
        for (int i = 0; i < OUT_LATCH_W; i++) begin
            wr(OFS_OUT_LATCH0, 8'h1 << i);
            step(2);
            chk("latch pins", 32'h1 << i, pins);
        end
        flash_wp_n <= 1'b0;
        keylock_request_in_n <= 1'b1;
        keyboard_secure_in_n <= 1'b0;
        step(4);
        rchk("in latch", OFS_IN_LATCH0, 8'h02);
        keylock_request_in_n <= 1'b0;
        step(4);
        rd(OFS_IN_LATCH0, d);
        wr(OFS_OUT_LATCH0, {3'h0, d[IN_KEYLOCK_BIT], 4'h0});
        step(2);
        chk("keylock mirror", keylock_request_in_n, keylock_out_n);
    endtask
    task automatic t_cpu();
        rchk("status after reset", OFS_STATUS, 8'h00);
        rchk("status idle", OFS_STATUS, 8'h00);
        pulse(16'h50);
        step(16);
        rchk("short pulse", OFS_STATUS, 8'h06);
        rchk("flags read", OFS_STATUS, 8'h00);
        pulse(16'h7d0);
        step(20);
        rchk("held", OFS_STATUS, 8'h05);
        chk("indicator held", 1'b1, system_reset_indicator);
        step(250);
        rchk("released", OFS_STATUS, 8'h02);
        chk("indicator free", 1'b0, system_reset_indicator);
    endtask
    task automatic t_power();
        wr(OFS_CTRL, 8'h01);
        step(2);
        chk("forced", 1'b0, cpu_power_ok_control);
        wr(OFS_CTRL, 8'h00);
        step(2);
        chk("unforced", 1'b1, cpu_power_ok_control);
        front_panel_a <= 1'b1;
        step(4);
        chk("panel reset", 1'b0, cpu_power_ok_control);
        front_panel_a <= 1'b0;
        mgmt_reset_request_n <= 1'b0;
        step(4);
        chk("request", 1'b1, mgmt_controller_reset);
        mgmt_reset_request_n <= 1'b1;
        step(4);
        chk("request gone", 1'b0, mgmt_controller_reset);
        wr_resp(OFS_STATUS, 8'h00, RESP_SLVERR);
        rchk("last reset", OFS_STATUS, 8'h08);
        wr(OFS_CTRL, 8'h01);
        pulse(16'h50);
        step(16);
        supply_ok_in <= 1'b0;
        step(4);
        chk("supply low", 1'b1, mgmt_controller_reset);
        supply_ok_in <= 1'b1;
        step(4);
        rchk("force cleared", OFS_CTRL, 8'h00);
        rchk("loss clears", OFS_STATUS, 8'h00);
        chk("power back", 1'b1, cpu_power_ok_control);
    endtask
    task automatic t_irq();
        rchk("irq status", OFS_IRQ_STATUS, 8'h03);
        wr(OFS_IRQ_ENABLE, 8'h02);
        step(2);
        chk("irq on", 1'b1, irq);
        wr(OFS_IRQ_ENABLE, 8'h00);
        step(2);
        chk("irq masked", 1'b0, irq);
        wr(OFS_IRQ_CLEAR, 8'h03);
        rchk("irq cleared", OFS_IRQ_STATUS, 8'h00);
        rchk("clear reg", OFS_IRQ_CLEAR, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h07);
        step(2);
        chk("irq idle", 1'b0, irq);
    endtask
    task automatic t_tick();
        logic [31:0] d;
        int total = 0;
        rd(OFS_TICK, d);
        burst(12'h28);
        rd(OFS_TICK, d);
        chk("tick count", 32'h05, d);
        total += d;
        rchk("tick cleared", OFS_TICK, 8'h00);
        burst(12'h820);
        chk("irq saturated", 1'b1, irq);
        rd(OFS_TICK, d);
        chk("tick saturated", {24'h0, TICK_MAX}, d);
        if (d[7:0] != TICK_MAX) total += d;
        rchk("irq sat bit", OFS_IRQ_STATUS, 8'h04);
        rchk("tick after", OFS_TICK, 8'h00);
        chk("tick total", 32'h05, total);
        chk("elapsed seconds", 32'h0, total >> 12);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(8);
        rst <= 1'b0;
        step(4);
        t_latch();
        t_cpu();
        t_power();
        t_irq();
        t_tick();
        print_verdict();
    end
    // tick saturation dominates, about 24k cycles
    initial begin
        step(60000);
        mismatches++;
        print_verdict();
    end
endmodule
bind mrsync_top mrsync_monitor mrsync_monitor_inst (.*);
